// *** pkg/hmr_map.svh ***
// Register offsets, field positions, reset values and timing counts of the harvester register bank.
`ifndef HMR_MAP_SVH
`define HMR_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define HMR_ADDR_IDENTITY   4'h0
`define HMR_ADDR_STATUS     4'h1
`define HMR_ADDR_EVENTS     4'h2
`define HMR_ADDR_MASK       4'h3
`define HMR_ADDR_REGCFG     4'h4
`define HMR_ADDR_ALERTCFG   4'h5
`define HMR_ADDR_TRACKCFG   4'h6
`define HMR_ADDR_MEASUREMENT_CONFIG    4'h7
`define HMR_ADDR_DEVCTL     4'h8
`define HMR_ADDR_VOLTAGE    4'h9
`define HMR_ADDR_CNT_HIGH   4'hA
`define HMR_ADDR_CNT_LOW    4'hB
`define HMR_ADDR_SLEEP_THD  4'hC

// ----------------------------------------------------------------------------
// Power-up defaults (first variant)
// ----------------------------------------------------------------------------
`define HMR_RST_REGCFG      8'h07
`define HMR_RST_ALERTCFG    8'h87
`define HMR_RST_TRACKCFG    8'h19
`define HMR_RST_MEASUREMENT_CONFIG     8'h0E
`define HMR_RST_DEVCTL      8'h30
`define HMR_RST_VOLTAGE     8'h1D
`define HMR_RST_ZERO        8'h00

// ----------------------------------------------------------------------------
// Field positions and limits
// ----------------------------------------------------------------------------
`define HMR_BIT_FORCE       7
`define HMR_BIT_HARV_RDY    4
`define HMR_BIT_VOLT_RDY    3
`define HMR_BIT_SLEEP       2
`define HMR_BIT_WAKE_LOW    0
`define HMR_MEAS_WMASK      8'h3F
`define HMR_TRACK_WMASK     8'h1F
`define HMR_SLEEP_VOLTAGE   8'h1D
`define HMR_COUNT_MAX       16'hFFFF

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define HMR_SYNC_STAGES     3

`endif

// *** pkg/hmr_pkg.sv ***
// Types shared by the harvester register bank modules.
package hmr_pkg;

    // Host access phase of the register port.
    typedef enum logic [1:0] {
        HMR_IDLE  = 2'b00,
        HMR_READ  = 2'b01,
        HMR_WRITE = 2'b11
    } hmr_access_e;

    // One 8-bit register value.
    typedef logic [7:0] hmr_byte_t;

endpackage

// *** rtl/hmr_sync.sv ***
// Three-stage synchroniser with agreement filter for an asynchronous level.
`timescale 1ns/1ps
`default_nettype none

module hmr_sync (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // Asynchronous level in, filtered level out.
    input  wire logic i_async,
    output logic      o_level
);

    // ------------------------------------------------------------------------
    // Shift chain
    // ------------------------------------------------------------------------
    logic stage1;  // Metastable stage, read only by stage2.
    logic stage2;  // First settled copy.
    logic stage3;  // Second settled copy.

    // The level only moves once the two settled stages agree, filtering glitches.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            o_level <= 1'b0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                o_level <= stage3;
            end
        end
    end

endmodule

`default_nettype wire

// *** rtl/hmr_pulse_counter.sv ***
// Saturating 16-bit counter of boost switching pulses.
`timescale 1ns/1ps
`default_nettype none
`include "hmr_map.svh"

module hmr_pulse_counter (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Control.
    input  wire logic        i_count,
    input  wire logic        i_clear,
    input  wire logic        i_sleep,
    // Count value and update strobe.
    output logic [15:0]      o_count,
    output logic             o_updated
);

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    // Clear restarts a harvest window; sleep stops counting, but a clear still zeroes the count.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_count   <= 16'h0000;
            o_updated <= 1'b0;
        end else begin
            o_updated <= 1'b0;
            if (i_clear) begin
                o_count <= 16'h0000;
            end else if (i_count && !i_sleep) begin
                if (o_count != `HMR_COUNT_MAX) begin
                    o_count <= o_count + 16'h0001;
                end
                o_updated <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// *** rtl/hmr_regs.sv ***
// Register bank of the solar harvester: voltage result, pulse counter and sleep control.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "hmr_map.svh"

module hmr_regs #(
    parameter logic [7:0] IDENTITY = 8'h5A  // Arbitrary identity value.
) (
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Register port from the serial host engine.
    input  wire logic [3:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    // Analogue side events and levels.
    input  wire logic       i_switch_node,
    input  wire logic       i_meas_done,
    input  wire logic [7:0] i_meas_value,
    input  wire logic       i_rail_low,
    input  wire logic       i_window_end,
    // Control outputs to the analogue side.
    output logic            o_start_meas,
    output logic            o_boost_halt,
    output logic            o_count_valid,
    output logic [7:0]      o_regcfg,
    output logic [7:0]      o_alertcfg,
    output logic [4:0]      o_track_fraction,
    output logic [7:0]      o_devctl,
    output logic [5:0]      o_measurement_config
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    hmr_pkg::hmr_byte_t regcfg;     // Output regulation settings.
    hmr_pkg::hmr_byte_t alertcfg;   // Alert threshold settings.
    logic [4:0]         trackcfg;   // Tracking fraction, upper bits reserved.
    logic [5:0]         measurement_config;    // Stored measurement settings.
    hmr_pkg::hmr_byte_t devctl;     // Device control bits.
    hmr_pkg::hmr_byte_t voltage;    // Latest source voltage result.
    hmr_pkg::hmr_byte_t sleep_thd;  // Count-based sleep limit.
    hmr_pkg::hmr_byte_t evt_mask;   // Event mask bits.
    logic [4:0]         events;     // Sticky change flags.
    logic               harv_rdy;   // Count updated since the high byte read.
    logic               volt_rdy;   // New voltage since the result read.
    logic               sleeping;   // Boost halted.
    logic               count_sleep;// Sleep caused by a short harvest.
    logic               pulse_lvl;  // Filtered switch node level.
    logic               pulse_prev; // Previous filtered level for edge find.
    logic               rail_low;   // Filtered rail-below-alert level.
    logic [15:0]        count;      // Live pulse count.
    logic               count_upd;  // A pulse was counted this cycle.
    hmr_pkg::hmr_access_e access;   // Current access kind.
    logic [4:0]         next_events;// Change flags raised this cycle.
    logic               wr_volt;    // Host writes the result register.
    logic               wr_force;   // Host sets the force bit.

    // Classifies the current bus strobe.
    function automatic hmr_pkg::hmr_access_e access_of(input logic wr, input logic rd);
        if (wr) begin
            return hmr_pkg::HMR_WRITE;
        end else if (rd) begin
            return hmr_pkg::HMR_READ;
        end
        return hmr_pkg::HMR_IDLE;
    endfunction

    // True when the strobe hits a given register.
    function automatic logic hit(input hmr_pkg::hmr_access_e a, input hmr_pkg::hmr_access_e k,
                                 input logic [3:0] ad, input logic [3:0] reg_addr);
        return (a == k) && (ad == reg_addr);
    endfunction

    assign access   = access_of(i_wr, i_rd);
    assign wr_volt  = hit(access, hmr_pkg::HMR_WRITE, i_addr, `HMR_ADDR_VOLTAGE);
    assign wr_force = hit(access, hmr_pkg::HMR_WRITE, i_addr, `HMR_ADDR_MEASUREMENT_CONFIG)
                      && i_wdata[`HMR_BIT_FORCE];

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Pin levels come from the analogue domain, so they are filtered first.
    hmr_sync u_sync_pulse (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_switch_node),
        .o_level  (pulse_lvl)
    );

    hmr_sync u_sync_rail (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_rail_low),
        .o_level  (rail_low)
    );

    // Edge detector on the settled pulse level.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pulse_prev <= 1'b0;
        end else begin
            pulse_prev <= pulse_lvl;
        end
    end

    // ------------------------------------------------------------------------
    // Pulse counter
    // ------------------------------------------------------------------------
    // The count restarts at each new voltage result, giving a harvest window.
    hmr_pulse_counter u_counter (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_count   (pulse_lvl && !pulse_prev),
        .i_clear   (i_meas_done),
        .i_sleep   (sleeping),
        .o_count   (count),
        .o_updated (count_upd)
    );

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    // Plain read-write settings; reserved bits are not stored.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            regcfg    <= `HMR_RST_REGCFG;
            alertcfg  <= `HMR_RST_ALERTCFG;
            trackcfg  <= 5'(`HMR_RST_TRACKCFG);
            measurement_config   <= 6'(`HMR_RST_MEASUREMENT_CONFIG);
            devctl    <= `HMR_RST_DEVCTL;
            sleep_thd <= `HMR_RST_ZERO;
            evt_mask  <= `HMR_RST_ZERO;
        end else if (access == hmr_pkg::HMR_WRITE) begin
            unique case (i_addr)
                `HMR_ADDR_REGCFG:    regcfg    <= i_wdata;
                `HMR_ADDR_ALERTCFG:  alertcfg  <= i_wdata & 8'hD7;
                `HMR_ADDR_TRACKCFG:  trackcfg  <= i_wdata[4:0];
                `HMR_ADDR_MEASUREMENT_CONFIG:   measurement_config   <= i_wdata[5:0];
                `HMR_ADDR_DEVCTL:    devctl    <= i_wdata & 8'h7F;
                `HMR_ADDR_SLEEP_THD: sleep_thd <= i_wdata;
                `HMR_ADDR_MASK:      evt_mask  <= i_wdata & 8'h1F;
                default: begin
                    // Read-only or unmapped addresses ignore writes.
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Forced measurement
    // ------------------------------------------------------------------------
    // The force bit is never stored: it raises one start pulse and so reads back as zero.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_start_meas <= 1'b0;
        end else begin
            o_start_meas <= wr_force;
        end
    end

    // ------------------------------------------------------------------------
    // Voltage result
    // ------------------------------------------------------------------------
    // A fresh measurement beats a same-cycle host write: it is newer data.
    // The host is expected not to write here while a force is pending.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            voltage <= `HMR_RST_VOLTAGE;
        end else if (i_meas_done) begin
            voltage <= i_meas_value;
        end else if (wr_volt) begin
            voltage <= i_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------------------
    // A short harvest window sleeps until the next result lands.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count_sleep <= 1'b0;
        end else if (i_meas_done) begin
            count_sleep <= 1'b0;
        end else if (i_window_end && sleep_thd != `HMR_RST_ZERO
                     && count < {8'h00, sleep_thd}) begin
            count_sleep <= 1'b1;
        end
    end

    // Low voltage sleep follows the stored value directly, so writes wake it.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sleeping     <= 1'b0;
            o_boost_halt <= 1'b0;
        end else begin
            sleeping     <= (voltage < `HMR_SLEEP_VOLTAGE) || count_sleep;
            o_boost_halt <= (voltage < `HMR_SLEEP_VOLTAGE) || count_sleep;
        end
    end

    // ------------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------------
    // Hardware sets win over read clears landing in the same cycle.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            harv_rdy <= 1'b0;
            volt_rdy <= 1'b0;
        end else begin
            if (count_upd) begin
                harv_rdy <= 1'b1;
            end else if (hit(access, hmr_pkg::HMR_READ, i_addr, `HMR_ADDR_CNT_HIGH)) begin
                harv_rdy <= 1'b0;
            end
            if (i_meas_done) begin
                volt_rdy <= 1'b1;
            end else if (hit(access, hmr_pkg::HMR_READ, i_addr, `HMR_ADDR_VOLTAGE)) begin
                volt_rdy <= 1'b0;
            end
        end
    end

    // Change flags for the harv_rdy and volt_rdy status bits; a read clears all except those raised in the same cycle.
    always_comb begin
        next_events    = 5'b00000;
        next_events[4] = count_upd && !harv_rdy;
        next_events[3] = i_meas_done && !volt_rdy;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            events <= 5'b00000;
        end else if (hit(access, hmr_pkg::HMR_READ, i_addr, `HMR_ADDR_EVENTS)) begin
            events <= next_events;
        end else begin
            events <= events | next_events;
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Data is registered one cycle after the read strobe; unmapped reads give zero.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (access == hmr_pkg::HMR_READ) begin
            unique case (i_addr)
                `HMR_ADDR_IDENTITY:  o_rdata <= IDENTITY;
                `HMR_ADDR_STATUS:    o_rdata <= {3'b000, harv_rdy, volt_rdy, sleeping, 1'b0,
                                                 rail_low};
                `HMR_ADDR_EVENTS:    o_rdata <= {3'b000, events};
                `HMR_ADDR_MASK:      o_rdata <= evt_mask;
                `HMR_ADDR_REGCFG:    o_rdata <= regcfg;
                `HMR_ADDR_ALERTCFG:  o_rdata <= alertcfg;
                `HMR_ADDR_TRACKCFG:  o_rdata <= {3'b000, trackcfg};
                `HMR_ADDR_MEASUREMENT_CONFIG:   o_rdata <= {2'b00, measurement_config};
                `HMR_ADDR_DEVCTL:    o_rdata <= devctl;
                `HMR_ADDR_VOLTAGE:   o_rdata <= voltage;
                `HMR_ADDR_CNT_HIGH:  o_rdata <= count[15:8];
                `HMR_ADDR_CNT_LOW:   o_rdata <= count[7:0];
                `HMR_ADDR_SLEEP_THD: o_rdata <= sleep_thd;
                default:             o_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registered control outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_count_valid    <= 1'b0;
            o_regcfg         <= `HMR_RST_REGCFG;
            o_alertcfg       <= `HMR_RST_ALERTCFG;
            o_track_fraction <= 5'(`HMR_RST_TRACKCFG);
            o_devctl         <= `HMR_RST_DEVCTL;
            o_measurement_config        <= 6'(`HMR_RST_MEASUREMENT_CONFIG);
        end else begin
            o_count_valid    <= !rail_low;
            o_regcfg         <= regcfg;
            o_alertcfg       <= alertcfg;
            o_track_fraction <= trackcfg;
            o_devctl         <= devctl;
            o_measurement_config        <= measurement_config;
        end
    end

endmodule

`default_nettype wire

// *** tb/hmr_regs_chk.sv ***
// Port checker of the harvester register bank.
`timescale 1ns/1ps
`default_nettype none
// ------------
// Checker
// ------------
module hmr_regs_chk #(
    parameter logic [7:0] IDENTITY = 8'h5A  // Arbitrary identity value.
) (
    // Clock and reset.
    input wire logic       i_clk,
    input wire logic       i_resetn,
    // Register port.
    input wire logic [3:0] i_addr,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    // Analogue side.
    input wire logic       i_meas_done,
    input wire logic [7:0] i_meas_value,
    input wire logic       i_rail_low,
    input wire logic       o_start_meas,
    input wire logic       o_boost_halt,
    input wire logic       o_count_valid,
    input wire logic [4:0] o_track_fraction
);
    // One domain, so clock and reset are given once.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Result code below the sleep level, by host write or by measurement.
    sequence s_low_write;
        i_wr && i_addr == 4'h9 && i_wdata < 8'h1D && !i_meas_done;
    endsequence
    sequence s_low_meas;
        i_meas_done && i_meas_value < 8'h1D;
    endsequence
    // A plain read, with no write competing for the edge.
    sequence s_read;
        i_rd && !i_wr;
    endsequence

    property p_start;
        i_wr && i_addr == 4'h7 && i_wdata[7] |=> o_start_meas;
    endproperty
    property p_halt_write;
        s_low_write |-> ##2 o_boost_halt;
    endproperty
    property p_halt_meas;
        s_low_meas |-> ##2 o_boost_halt;
    endproperty
    // The filter may add a few cycles, so eight stable samples are asked.
    property p_valid_high;
        (!i_rail_low)[*8] |-> o_count_valid;
    endproperty
    property p_valid_low;
        i_rail_low[*8] |-> !o_count_valid;
    endproperty
    property p_read_quiet;
        s_read |=> !o_start_meas;
    endproperty
    property p_unmapped;
        s_read and (i_addr > 4'hC) |=> o_rdata == 8'h00;
    endproperty
    property p_identity;
        s_read and (i_addr == 4'h0) |=> o_rdata == IDENTITY;
    endproperty
    property p_track;
        (i_wr && i_addr == 4'h6) |-> ##2 o_track_fraction == $past(i_wdata[4:0], 2);
    endproperty

    a_start: assert property (p_start) else $error("force write gave no start pulse");
    a_halt_write: assert property (p_halt_write) else $error("low write left boost on");
    a_halt_meas: assert property (p_halt_meas) else $error("low result left boost on");
    a_valid_high: assert property (p_valid_high) else $error("count not valid");
    a_valid_low: assert property (p_valid_low) else $error("count valid on low rail");
    a_read_quiet: assert property (p_read_quiet) else $error("read started a measure");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_identity: assert property (p_identity) else $error("identity read wrong");
    a_track: assert property (p_track) else $error("fraction copy wrong");
endmodule

bind hmr_regs hmr_regs_chk #(.IDENTITY(IDENTITY)) u_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_meas_done(i_meas_done),
    .i_meas_value(i_meas_value), .i_rail_low(i_rail_low), .o_start_meas(o_start_meas),
    .o_boost_halt(o_boost_halt), .o_count_valid(o_count_valid),
    .o_track_fraction(o_track_fraction));
`default_nettype wire

// *** tb/hmr_host.sv ***
// Behavioural host controller that drives the register port.
`timescale 1ns/1ps
`default_nettype none
module hmr_host (
    // Clock.
    input wire logic        i_clk,
    // Register port towards the bank.
    output logic      [3:0] o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata,
    input  wire logic [7:0] i_rdata
);
    // Idle bus at time zero.
    initial begin
        o_addr = 4'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // One write; the spare cycle at the end lets a forced measure
    // clear before any later result write.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;  // Released lines never keep the old value.
        o_wdata = ~d;
        @(posedge i_clk);
        #1;
    endtask
    // One read; data is taken after the edge that answers.
    task automatic rd(input logic [3:0] a, output hmr_pkg::hmr_byte_t q);
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        @(posedge i_clk);
        #1;
        q = i_rdata;
    endtask
endmodule
`default_nettype wire

// *** tb/hmr_regs_bench.sv ***
// Self-checking bench of the harvester register bank.
`timescale 1ns/1ps
`default_nettype none
module hmr_regs_bench;
    localparam logic [7:0] ID = 8'h3C;  // Arbitrary identity value.
    // ------------
    // Signals
    // ------------
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [3:0] addr;
    logic       wr, rd, sw = 1'b0, mdone = 1'b0, rlow = 1'b0, wend = 1'b0;
    logic [7:0] wdata, rdata, mval = 8'h00, regcfg, alertcfg, devctl;
    logic       start, halt, valid;
    logic [4:0] track;
    logic [5:0] measurement_config;
    int         err_total = 0, cmp_count = 0, starts = 0;

    always #5 clk = ~clk;
    // Start pulses are counted at the edge, as they stand one cycle only.
    always @(posedge clk) if (start === 1'b1) starts++;

    hmr_regs #(.IDENTITY(ID)) u_dut (.i_clk(clk), .i_resetn(rstn), .i_addr(addr),
        .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .i_switch_node(sw),
        .i_meas_done(mdone), .i_meas_value(mval), .i_rail_low(rlow), .i_window_end(wend),
        .o_start_meas(start), .o_boost_halt(halt), .o_count_valid(valid),
        .o_regcfg(regcfg), .o_alertcfg(alertcfg), .o_track_fraction(track),
        .o_devctl(devctl), .o_measurement_config(measurement_config));
    hmr_host u_host (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
        .i_rdata(rdata));

    // ------------
    // Helpers
    // ------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdv(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.rd(a, q);
        chk(q, e);
    endtask
    // Each pulse is long enough to pass the pin filter.
    task automatic pulses(input int n);
        repeat (n) begin
            sw = 1'b1;
            tick(3);
            sw = 1'b0;
            tick(3);
        end
        tick(6);
    endtask
    task automatic meas(input logic [7:0] v);
        mdone = 1'b1;
        mval = v;
        tick(1);
        mdone = 1'b0;
        tick(3);
    endtask
    task automatic window();
        wend = 1'b1;
        tick(1);
        wend = 1'b0;
        tick(3);
    endtask

    // ------------
    // Scenarios
    // ------------
    task automatic t_defaults();
        logic [7:0] e [14];
        e = '{ID, 8'h00, 8'h00, 8'h00, 8'h07, 8'h87, 8'h19, 8'h0E, 8'h30, 8'h1D, 8'h00,
              8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 14; i++) rdv(4'(i), e[i]);
        u_host.wr(4'h0, 8'hFF);
        u_host.wr(4'hA, 8'hFF);
        u_host.wr(4'h6, 8'hFF);
        rdv(4'h0, ID);
        rdv(4'hA, 8'h00);
        rdv(4'h6, 8'h1F);
        chk(16'(track), 16'h001F);
        $display("t_defaults done");
    endtask
    task automatic t_voltage();
        int s;
        s = starts;
        u_host.wr(4'h9, 8'h1C);
        chk(16'(halt), 16'h0001);
        rdv(4'h9, 8'h1C);
        rdv(4'h9, 8'h1C);
        chk(16'(starts - s), 16'h0000);
        u_host.wr(4'h9, 8'h1D);
        tick(1);
        chk(16'(halt), 16'h0000);
        meas(8'h05);
        chk(16'(halt), 16'h0001);
        rdv(4'h9, 8'h05);
        meas(8'hFF);
        chk(16'(halt), 16'h0000);
        rdv(4'h9, 8'hFF);
        $display("t_voltage done");
    endtask
    task automatic t_count();
        logic [7:0] q;
        meas(8'h40);
        pulses(3);
        u_host.rd(4'h1, q);
        chk(16'(q & 8'h10), 16'h0010);
        rdv(4'hA, 8'h00);
        rdv(4'hB, 8'h03);
        u_host.rd(4'h1, q);
        chk(16'(q & 8'h10), 16'h0000);
        u_host.wr(4'h9, 8'h05);
        pulses(2);
        rdv(4'hB, 8'h03);
        u_host.wr(4'h9, 8'h40);
        window();
        chk(16'(halt), 16'h0000);
        u_host.wr(4'hC, 8'h04);
        window();
        chk(16'(halt), 16'h0001);
        meas(8'h40);
        chk(16'(halt), 16'h0000);
        rdv(4'hB, 8'h00);
        pulses(4);
        window();
        chk(16'(halt), 16'h0000);
        rlow = 1'b1;
        tick(10);
        chk(16'(valid), 16'h0000);
        rlow = 1'b0;
        tick(10);
        chk(16'(valid), 16'h0001);
        $display("t_count done");
    endtask
    task automatic t_force();
        int s;
        s = starts;
        u_host.wr(4'h7, 8'h8E);
        tick(3);
        chk(16'(starts - s), 16'h0001);
        rdv(4'h7, 8'h0E);
        $display("t_force done");
    endtask
    task automatic t_config();
        logic [7:0] q;
        u_host.wr(4'h4, 8'hA5);
        u_host.wr(4'h5, 8'hFF);
        u_host.wr(4'h8, 8'hFF);
        u_host.wr(4'h3, 8'hFF);
        u_host.wr(4'h7, 8'h3F);
        chk({regcfg, alertcfg}, 16'hA5D7);
        chk({devctl, 2'b00, measurement_config}, 16'h7F3F);
        rdv(4'h4, 8'hA5);
        rdv(4'h5, 8'hD7);
        rdv(4'h8, 8'h7F);
        rdv(4'h3, 8'h1F);
        rdv(4'h7, 8'h3F);
        rdv(4'hC, 8'h04);
        u_host.rd(4'h2, q);
        rdv(4'h9, 8'h40);
        meas(8'h50);
        rdv(4'h2, 8'h08);
        rdv(4'h2, 8'h00);
        $display("t_config done");
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The scenarios need well under two thousand cycles.
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_defaults();
        t_voltage();
        t_count();
        t_force();
        t_config();
        finish_test();
    end
endmodule
`default_nettype wire
